/* design/gpc_cfg.svh */
// Purpose: Address map, fields and reset values of the GPIO port
// Assumes: 32-bit AXI4-Lite register bus, byte addresses
// Notes:   Shared by package and design
`ifndef GPC_CFG_SVH
`define GPC_CFG_SVH

// ==========================================================
// Register byte offsets
`define GPC_OFS_DIR_OUT      12'h000
`define GPC_OFS_IN_LEVEL     12'h004
`define GPC_OFS_WR_GUARD     12'h008
`define GPC_OFS_PFS_BASE     12'h040
`define GPC_PFS_STRIDE_LOG2  2
`define GPC_ADDR_W           12

// ==========================================================
// Port control direction/output word: direction low half, latch high half
`define GPC_DIR_LSB          0
`define GPC_OLAT_LSB         16

// ==========================================================
// Pin function select fields
`define GPC_PFS_OLAT         0
`define GPC_PFS_INPUT        1
`define GPC_PFS_DIR          2
`define GPC_PFS_PULLUP       4
`define GPC_PFS_OPEN_DRAIN   6
`define GPC_PFS_DRIVE_LSB    10
`define GPC_PFS_ANALOG       15
`define GPC_PFS_IRQ          14
`define GPC_PFS_MODE         16
`define GPC_PFS_PSEL_LSB     24
`define GPC_PSEL_W           5

// ==========================================================
// Write guard and reset values
`define GPC_GUARD_ENABLE     0
`define GPC_RST_BIT          1'b0
`define GPC_RST_DRIVE        2'b00
`define GPC_RST_PSEL         5'h00

// ==========================================================
// Bus responses
`define GPC_RESP_OKAY        2'b00
`define GPC_RESP_SLVERR      2'b10

`endif

/* design/gpc_pkg.sv */
// Purpose: Types shared by the GPIO pin configuration port
// Assumes: Constants from gpc_cfg.svh
// Notes:   Types only, no logic
`include "gpc_cfg.svh"

package gpc_pkg;

    // Drive strength codes; the code between middle and high is not legal
    typedef enum logic [1:0] {
        GPC_DRIVE_LOW  = 2'b00,
        GPC_DRIVE_MID  = 2'b01,
        GPC_DRIVE_BAD  = 2'b10,
        GPC_DRIVE_HIGH = 2'b11
    } gpc_drive_t;

    typedef logic [`GPC_ADDR_W-1:0] gpc_addr_t;

endpackage : gpc_pkg

/* design/gpc_sync.sv */
// Purpose: Two-flop synchroniser for the pin input levels
// Assumes: Inputs are asynchronous to aclk
// Notes:   First stage feeds only the second stage
`timescale 1ns/1ps

module gpc_sync
    import gpc_pkg::*;
#(
    parameter int WIDTH = 16
) (
    // Clock and reset
    input  wire logic             aclk,
    input  wire logic             aresetn,
    // Data
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_reg;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta_reg <= '0;
            sync_out <= '0;
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end

endmodule : gpc_sync

/* design/gpc_axil_slave.sv */
// Purpose: AXI4-Lite handshake engine for the GPIO port registers
// Assumes: One write and one read under way at a time
// Notes:   wr_go and rd_go are one-cycle pulses
`timescale 1ns/1ps
`include "gpc_cfg.svh"

module gpc_axil_slave
    import gpc_pkg::*;
(
    // Clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // Write address and data
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] awaddr,
    input  wire logic        wvalid,
    output logic             wready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    // Write response
    output logic             bvalid,
    input  wire logic        bready,
    output logic [1:0]       bresp,
    // Read address and data
    input  wire logic        arvalid,
    output logic             arready,
    input  wire logic [31:0] araddr,
    output logic             rvalid,
    input  wire logic        rready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    // Register file side
    output logic             wr_go,
    output gpc_addr_t        wr_addr,
    output logic [31:0]      wr_data,
    output logic [3:0]       wr_strb,
    input  wire logic        wr_err,
    output logic             rd_go,
    output gpc_addr_t        rd_addr,
    input  wire logic [31:0] rd_data,
    input  wire logic        rd_err
);

    assign wr_go = !awready && !wready && !bvalid;
    assign rd_go = !arready && !rvalid;

    // ==========================================================
    // Write channels: address and data taken in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready <= 1'b1;
            wready  <= 1'b1;
            bvalid  <= 1'b0;
            bresp   <= `GPC_RESP_OKAY;
            wr_addr <= '0;
            wr_data <= '0;
            wr_strb <= '0;
        end else begin
            if (awvalid && awready) begin
                awready <= 1'b0;
                wr_addr <= awaddr[`GPC_ADDR_W-1:0];
            end
            if (wvalid && wready) begin
                wready  <= 1'b0;
                wr_data <= wdata;
                wr_strb <= wstrb;
            end
            if (wr_go) begin
                bvalid <= 1'b1;
                bresp  <= wr_err ? `GPC_RESP_SLVERR : `GPC_RESP_OKAY;
            end
            if (bvalid && bready) begin
                bvalid  <= 1'b0;
                awready <= 1'b1;
                wready  <= 1'b1;
            end
        end
    end

    // ==========================================================
    // Read channels
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b1;
            rvalid  <= 1'b0;
            rdata   <= '0;
            rresp   <= `GPC_RESP_OKAY;
            rd_addr <= '0;
        end else begin
            if (arvalid && arready) begin
                arready <= 1'b0;
                rd_addr <= araddr[`GPC_ADDR_W-1:0];
            end
            if (rd_go) begin
                rvalid <= 1'b1;
                rdata  <= rd_data;
                rresp  <= rd_err ? `GPC_RESP_SLVERR : `GPC_RESP_OKAY;
            end
            if (rvalid && rready) begin
                rvalid  <= 1'b0;
                arready <= 1'b1;
            end
        end
    end

endmodule : gpc_axil_slave

/* design/gpc_port.sv */
// Purpose: One GPIO port with per-pin function select
// Assumes: All inputs on aclk except pin_in
// Notes:   Pin outputs are registered, one cycle after the configuration changes
//
// Functional notes
// - Direction bit: one output, zero input, resets to input, readable.
// - Reading output data returns the latch, never the pin level.
// - Input-level register is read-only and shows sampled pin levels.
// - Mode bit resets to GPIO; one hands pin to selected peripheral.
// - All pull-up enables clear at reset.
// - Pull-up forced off for external bus, GPIO output, peripheral output.
// - Push-pull by default; open-drain bit one selects open-drain output.
// - Drive codes: 00 low, 01 middle, 11 high; 10 is refused.
// - All drive strength fields clear to low drive at reset.
// - Drive selection on ports 1 to 9; high drive only on one variant.
// - Each pin owns a function select register with mode, selection, irq, analog.
// - Function select registers are write-guarded after reset until enabled.
//
// The AXI4-Lite slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "gpc_cfg.svh"

module gpc_port
    import gpc_pkg::*;
#(
    parameter int NUM_PINS   = 16,
    parameter int PORT_NUM   = 1,
    parameter bit HIGH_DRIVE = 1'b1
) (
    // Clock and reset
    input  wire logic                         aclk,
    input  wire logic                         aresetn,
    // AXI4-Lite write address and data
    input  wire logic                         s_axi_awvalid,
    output logic                              s_axi_awready,
    input  wire logic [31:0]                  s_axi_awaddr,
    input  wire logic                         s_axi_wvalid,
    output logic                              s_axi_wready,
    input  wire logic [31:0]                  s_axi_wdata,
    input  wire logic [3:0]                   s_axi_wstrb,
    // AXI4-Lite write response
    output logic                              s_axi_bvalid,
    input  wire logic                         s_axi_bready,
    output logic [1:0]                        s_axi_bresp,
    // AXI4-Lite read
    input  wire logic                         s_axi_arvalid,
    output logic                              s_axi_arready,
    input  wire logic [31:0]                  s_axi_araddr,
    output logic                              s_axi_rvalid,
    input  wire logic                         s_axi_rready,
    output logic [31:0]                       s_axi_rdata,
    output logic [1:0]                        s_axi_rresp,
    // Pads
    input  wire logic [NUM_PINS-1:0]          pin_in,
    output logic      [NUM_PINS-1:0]          pin_out,
    output logic      [NUM_PINS-1:0]          pin_oe,
    output logic      [NUM_PINS-1:0]          pullup_on,
    output logic      [2*NUM_PINS-1:0]        drive_strength,
    // Peripheral side
    input  wire logic [NUM_PINS-1:0]          periph_out,
    input  wire logic [NUM_PINS-1:0]          periph_oe,
    input  wire logic [NUM_PINS-1:0]          ext_bus_pin,
    output logic      [NUM_PINS-1:0]          periph_in,
    output logic      [`GPC_PSEL_W*NUM_PINS-1:0] periph_sel,
    output logic      [NUM_PINS-1:0]          irq_in_en,
    output logic      [NUM_PINS-1:0]          analog_en
);

    // ==========================================================
    // Register storage
    logic [NUM_PINS-1:0]    dir_reg;
    logic [NUM_PINS-1:0]    olat_reg;
    logic [NUM_PINS-1:0]    mode_reg;
    logic [NUM_PINS-1:0]    pull_reg;
    logic [NUM_PINS-1:0]    od_reg;
    logic [NUM_PINS-1:0]    irq_reg;
    logic [NUM_PINS-1:0]    ana_reg;
    logic [1:0]             drive_reg [NUM_PINS];
    logic [`GPC_PSEL_W-1:0] psel_reg  [NUM_PINS];
    logic                   guard_reg;

    // Bus engine wiring
    logic        wr_go;
    gpc_addr_t   wr_addr;
    logic [31:0] wr_data;
    logic [3:0]  wr_strb;
    logic        wr_err;
    logic        rd_go;
    gpc_addr_t   rd_addr;
    logic [31:0] rd_data;
    logic        rd_err;
    logic [NUM_PINS-1:0] pin_sync;

    // Drive selection exists only on the middle ports
    localparam bit HAS_DRIVE = (PORT_NUM >= 1) && (PORT_NUM <= 9);
    localparam bit HAS_PULL  = (PORT_NUM >= 0) && (PORT_NUM <= 9);

    // ==========================================================
    // Helpers
    function automatic logic [31:0] strb_mask(input logic [3:0] strb);
        logic [31:0] m;
        m = '0;
        for (int b = 0; b < 4; b++) begin
            m[b*8 +: 8] = {8{strb[b]}};
        end
        return m;
    endfunction : strb_mask

    // Pin index of a function select address, or -1 when outside the block
    function automatic int pfs_index(input gpc_addr_t a);
        int idx;
        idx = -1;
        if (a >= `GPC_OFS_PFS_BASE &&
            a < gpc_addr_t'(`GPC_OFS_PFS_BASE + (NUM_PINS << `GPC_PFS_STRIDE_LOG2)) &&
            a[1:0] == 2'b00) begin
            idx = int'((a - `GPC_OFS_PFS_BASE) >> `GPC_PFS_STRIDE_LOG2);
        end
        return idx;
    endfunction : pfs_index

    function automatic logic addr_mapped(input gpc_addr_t a);
        return (a == `GPC_OFS_DIR_OUT) || (a == `GPC_OFS_IN_LEVEL) ||
               (a == `GPC_OFS_WR_GUARD) || (pfs_index(a) >= 0);
    endfunction : addr_mapped

    // Refuse the illegal code, and high drive on the variant without it
    function automatic logic drive_legal(input logic [1:0] code);
        return (code != GPC_DRIVE_BAD) && (HIGH_DRIVE || code != GPC_DRIVE_HIGH);
    endfunction : drive_legal

    // ==========================================================
    // Bus engine and input synchroniser
    gpc_axil_slave u_axil (
        .aclk    (aclk),
        .aresetn (aresetn),
        .awvalid (s_axi_awvalid),
        .awready (s_axi_awready),
        .awaddr  (s_axi_awaddr),
        .wvalid  (s_axi_wvalid),
        .wready  (s_axi_wready),
        .wdata   (s_axi_wdata),
        .wstrb   (s_axi_wstrb),
        .bvalid  (s_axi_bvalid),
        .bready  (s_axi_bready),
        .bresp   (s_axi_bresp),
        .arvalid (s_axi_arvalid),
        .arready (s_axi_arready),
        .araddr  (s_axi_araddr),
        .rvalid  (s_axi_rvalid),
        .rready  (s_axi_rready),
        .rdata   (s_axi_rdata),
        .rresp   (s_axi_rresp),
        .wr_go   (wr_go),
        .wr_addr (wr_addr),
        .wr_data (wr_data),
        .wr_strb (wr_strb),
        .wr_err  (wr_err),
        .rd_go   (rd_go),
        .rd_addr (rd_addr),
        .rd_data (rd_data),
        .rd_err  (rd_err)
    );

    gpc_sync #(
        .WIDTH (NUM_PINS)
    ) u_sync (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .async_in (pin_in),
        .sync_out (pin_sync)
    );

    assign wr_err = !addr_mapped(wr_addr);
    assign rd_err = !addr_mapped(rd_addr);

    // ==========================================================
    // Write guard for the function select registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            guard_reg <= `GPC_RST_BIT;
        end else if (wr_go && wr_addr == `GPC_OFS_WR_GUARD && wr_strb[0]) begin
            guard_reg <= wr_data[`GPC_GUARD_ENABLE];
        end
    end

    // ==========================================================
    // Direction and output latch, shared by both register paths
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dir_reg  <= '0;
            olat_reg <= '0;
        end else if (wr_go) begin
            if (wr_addr == `GPC_OFS_DIR_OUT) begin
                for (int p = 0; p < NUM_PINS; p++) begin
                    if (strb_mask(wr_strb)[`GPC_DIR_LSB + p]) begin
                        dir_reg[p] <= wr_data[`GPC_DIR_LSB + p];
                    end
                    if (strb_mask(wr_strb)[`GPC_OLAT_LSB + p]) begin
                        olat_reg[p] <= wr_data[`GPC_OLAT_LSB + p];
                    end
                end
            end else if (pfs_index(wr_addr) >= 0 && guard_reg) begin
                if (wr_strb[0]) begin
                    dir_reg[pfs_index(wr_addr)]  <= wr_data[`GPC_PFS_DIR];
                    olat_reg[pfs_index(wr_addr)] <= wr_data[`GPC_PFS_OLAT];
                end
            end
        end
    end

    // ==========================================================
    // Per-pin function select fields
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_reg <= '0;
            pull_reg <= '0;
            od_reg   <= '0;
            irq_reg  <= '0;
            ana_reg  <= '0;
            for (int p = 0; p < NUM_PINS; p++) begin
                drive_reg[p] <= `GPC_RST_DRIVE;
                psel_reg[p]  <= `GPC_RST_PSEL;
            end
        end else if (wr_go && guard_reg && pfs_index(wr_addr) >= 0) begin
            if (wr_strb[0]) begin
                pull_reg[pfs_index(wr_addr)] <= HAS_PULL && wr_data[`GPC_PFS_PULLUP];
                od_reg[pfs_index(wr_addr)]   <= wr_data[`GPC_PFS_OPEN_DRAIN];
            end
            if (wr_strb[1]) begin
                if (HAS_DRIVE && drive_legal(wr_data[`GPC_PFS_DRIVE_LSB +: 2])) begin
                    drive_reg[pfs_index(wr_addr)] <= wr_data[`GPC_PFS_DRIVE_LSB +: 2];
                end
                irq_reg[pfs_index(wr_addr)] <= wr_data[`GPC_PFS_IRQ];
                ana_reg[pfs_index(wr_addr)] <= wr_data[`GPC_PFS_ANALOG];
            end
            if (wr_strb[2]) begin
                mode_reg[pfs_index(wr_addr)] <= wr_data[`GPC_PFS_MODE];
            end
            if (wr_strb[3]) begin
                psel_reg[pfs_index(wr_addr)] <= wr_data[`GPC_PFS_PSEL_LSB +: `GPC_PSEL_W];
            end
        end
    end

    // ==========================================================
    // Read multiplexer
    always_comb begin
        int idx;
        idx     = pfs_index(rd_addr);
        rd_data = '0;
        if (rd_addr == `GPC_OFS_DIR_OUT) begin
            rd_data[`GPC_DIR_LSB +: NUM_PINS]  = dir_reg;
            rd_data[`GPC_OLAT_LSB +: NUM_PINS] = olat_reg;
        end else if (rd_addr == `GPC_OFS_IN_LEVEL) begin
            rd_data[NUM_PINS-1:0] = pin_sync;
        end else if (rd_addr == `GPC_OFS_WR_GUARD) begin
            rd_data[`GPC_GUARD_ENABLE] = guard_reg;
        end else if (idx >= 0) begin
            rd_data[`GPC_PFS_OLAT]        = olat_reg[idx];
            rd_data[`GPC_PFS_INPUT]       = pin_sync[idx];
            rd_data[`GPC_PFS_DIR]         = dir_reg[idx];
            rd_data[`GPC_PFS_PULLUP]      = pull_reg[idx];
            rd_data[`GPC_PFS_OPEN_DRAIN]  = od_reg[idx];
            rd_data[`GPC_PFS_DRIVE_LSB +: 2] = drive_reg[idx];
            rd_data[`GPC_PFS_IRQ]         = irq_reg[idx];
            rd_data[`GPC_PFS_ANALOG]      = ana_reg[idx];
            rd_data[`GPC_PFS_MODE]        = mode_reg[idx];
            rd_data[`GPC_PFS_PSEL_LSB +: `GPC_PSEL_W] = psel_reg[idx];
        end
    end

    // ==========================================================
    // Pad drive; registered so every pad output is glitch-free
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_out        <= '0;
            pin_oe         <= '0;
            pullup_on      <= '0;
            drive_strength <= '0;
        end else begin
            for (int p = 0; p < NUM_PINS; p++) begin
                logic drv_val;
                logic drv_en;
                drv_val = mode_reg[p] ? periph_out[p] : olat_reg[p];
                drv_en  = mode_reg[p] ? periph_oe[p]  : dir_reg[p];
                // Open drain only ever pulls low; a high is left to the board, as the pull-up is off while drv_en is set
                pin_out[p] <= od_reg[p] ? 1'b0 : drv_val;
                pin_oe[p]  <= drv_en && !(od_reg[p] && drv_val);
                pullup_on[p] <= pull_reg[p] && !drv_en && !ext_bus_pin[p];
                drive_strength[2*p +: 2] <= drive_reg[p];
            end
        end
    end

    // ==========================================================
    // Peripheral side
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            periph_in  <= '0;
            periph_sel <= '0;
            irq_in_en  <= '0;
            analog_en  <= '0;
        end else begin
            for (int p = 0; p < NUM_PINS; p++) begin
                // Peripheral sees the pin only once handed over, so no stray edges
                periph_in[p] <= mode_reg[p] && pin_sync[p];
                periph_sel[`GPC_PSEL_W*p +: `GPC_PSEL_W] <= psel_reg[p];
            end
            irq_in_en <= irq_reg;
            analog_en <= ana_reg;
        end
    end

endmodule : gpc_port

/* sim/gpc_port_assertions.sv */
// Purpose: Port-level checks on gpc_port
// Assumes: One clock, sync active-low reset
// Notes:   Bound below
`timescale 1ns/1ps

module gpc_port_assertions #(
    parameter int NUM_PINS = 16
) (
    // Clock and reset
    input wire logic                  aclk,
    input wire logic                  aresetn,
    // Bus handshakes
    input wire logic                  s_axi_awvalid,
    input wire logic                  s_axi_awready,
    input wire logic                  s_axi_wvalid,
    input wire logic                  s_axi_wready,
    input wire logic                  s_axi_bvalid,
    input wire logic                  s_axi_bready,
    input wire logic [1:0]            s_axi_bresp,
    input wire logic                  s_axi_arvalid,
    input wire logic                  s_axi_arready,
    input wire logic                  s_axi_rvalid,
    input wire logic                  s_axi_rready,
    input wire logic [31:0]           s_axi_rdata,
    // Pads and peripherals
    input wire logic [NUM_PINS-1:0]   pin_in,
    input wire logic [NUM_PINS-1:0]   pin_oe,
    input wire logic [NUM_PINS-1:0]   pullup_on,
    input wire logic [2*NUM_PINS-1:0] drive_strength,
    input wire logic [NUM_PINS-1:0]   ext_bus_pin,
    input wire logic [NUM_PINS-1:0]   periph_in
);
    // ==========================================================
    // Helpers
    logic bad_code;
    always_comb begin
        bad_code = 1'b0;
        for (int p = 0; p < NUM_PINS; p++) begin
            if (drive_strength[2*p+:2] == 2'b10) begin
                bad_code = 1'b1;
            end
        end
    end
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_wr_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_rd_take;
        s_axi_arvalid && s_axi_arready;
    endsequence

    // ==========================================================
    // Checks
    a_wr_answer: assert property (s_wr_take |=> !s_axi_awready ##1 s_axi_bvalid)
        else $error("bvalid late");
    a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("bvalid dropped");
    a_aw_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write during response");
    a_rd_answer: assert property (s_rd_take |=> ##1 s_axi_rvalid)
        else $error("rvalid late");
    a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("rdata unstable");
    a_pullup_off: assert property ((pullup_on & (pin_oe | $past(ext_bus_pin))) == '0)
        else $error("pull-up while driven");
    a_drive_legal: assert property (!bad_code)
        else $error("bad drive code");
    a_sync_depth: assert property ((periph_in & ~$past(pin_in, 3)) == '0)
        else $error("periph_in early");
    a_reset_clear: assert property ($rose(aresetn) |-> (pin_oe | pullup_on) == '0 && drive_strength == '0)
        else $error("pads not reset");
endmodule : gpc_port_assertions

bind gpc_port gpc_port_assertions #(.NUM_PINS(NUM_PINS)) i_gpc_port_assertions (.*);

/* sim/testbench.sv */
// Purpose: Self-checking bench for gpc_port
// Assumes: 125 MHz aclk
// Notes:   bready/rready raised late
`timescale 1ns/1ps
`include "gpc_cfg.svh"

module testbench;
    localparam logic [31:0] PFS = `GPC_OFS_PFS_BASE;
    localparam logic [1:0]  OK  = `GPC_RESP_OKAY;
    logic        aclk = 1'b0, aresetn = 1'b0;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic [15:0] pin_in = '0, periph_out = '0, periph_oe = '0, ext_bus_pin = '0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata, drive_strength;
    logic [15:0] pin_out, pin_oe, pullup_on, periph_in, irq_in_en, analog_en;
    logic [79:0] periph_sel;
    int          n_errors = 0, n_checks = 0;

    gpc_port i_gpc_port (
        .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
        .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .pin_in,
        .pin_out, .pin_oe, .pullup_on, .drive_strength, .periph_out, .periph_oe, .ext_bus_pin, .periph_in,
        .periph_sel, .irq_in_en, .analog_en
    );

    always #4 aclk = ~aclk;

    // ==========================================================
    // Bus and check helpers
    task automatic step(input int n);
        repeat (n) @(posedge aclk);
    endtask : step

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("Error t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) s_axi_bready <= 1'b1;
        end while (!(s_axi_bvalid && s_axi_bready));
        s_axi_bready <= 1'b0;
        chk(s_axi_bresp, er, "bresp");
    endtask : wr

    task automatic rd(input logic [31:0] a, input logic [31:0] exp, input logic [1:0] er, input string what);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) s_axi_rready <= 1'b1;
        end while (!(s_axi_rvalid && s_axi_rready));
        s_axi_rready <= 1'b0;
        chk(s_axi_rdata, exp, what);
        chk(s_axi_rresp, er, "rresp");
    endtask : rd

    // ==========================================================
    // Scenarios
    task automatic t_reset;
        rd(`GPC_OFS_DIR_OUT, '0, OK, "dir reset");
        rd(PFS + 4, '0, OK, "pfs reset");
        chk({pin_oe, pullup_on}, '0, "pad reset");
        chk(drive_strength, '0, "drive reset");
        rd(32'h0000_0ffc, '0, `GPC_RESP_SLVERR, "unmapped");
        wr(32'h0000_0ffc, 32'hffff_ffff, `GPC_RESP_SLVERR);
    endtask : t_reset

    task automatic t_guard;
        wr(PFS, 32'h0001_0000, OK);
        rd(PFS, '0, OK, "guarded");
        wr(`GPC_OFS_WR_GUARD, 32'h0000_0001, OK);
        wr(PFS, 32'h0000_0002, OK);
        rd(PFS, '0, OK, "input ro");
    endtask : t_guard

    task automatic t_gpio;
        wr(`GPC_OFS_DIR_OUT, 32'h0005_0000, OK);
        step(1);
        chk(pin_oe, '0, "latch first");
        wr(`GPC_OFS_DIR_OUT, 32'h0005_0003, OK);
        step(1);
        chk({pin_oe, pin_out & pin_oe}, 32'h0003_0001, "push pull");
        rd(`GPC_OFS_DIR_OUT, 32'h0005_0003, OK, "latch not pin");
        wr(PFS + 4, 32'h0000_0005, OK);
        rd(`GPC_OFS_DIR_OUT, 32'h0007_0003, OK, "shared");
        rd(PFS, 32'h0000_0005, OK, "shared pfs");
        wr(PFS, 32'h0000_0045, OK);
        step(1);
        chk({pin_oe[0], pin_out[0]}, 2'b00, "od high");
        wr(PFS, 32'h0000_0044, OK);
        step(1);
        chk({pin_oe[0], pin_out[0]}, 2'b10, "od low");
    endtask : t_gpio

    task automatic t_pullup;
        wr(PFS + 12, 32'h0000_0010, OK);
        step(1);
        chk(pullup_on, 16'h0008, "pullup on");
        ext_bus_pin <= 16'h0008;
        step(2);
        chk(pullup_on, '0, "ext bus");
        ext_bus_pin <= '0;
        wr(PFS + 12, 32'h0000_0014, OK);
        step(1);
        chk(pullup_on, '0, "output");
    endtask : t_pullup

    task automatic t_drive;
        logic [1:0] code [4] = '{2'b01, 2'b10, 2'b11, 2'b00};
        logic [1:0] kept [4] = '{2'b01, 2'b01, 2'b11, 2'b00};
        for (int i = 0; i < 4; i++) begin
            wr(PFS + 16, {20'h0_0000, code[i], 10'h000}, OK);
            step(1);
            chk(drive_strength[9:8], kept[i], "drive pad");
            rd(PFS + 16, {20'h0_0000, kept[i], 10'h000}, OK, "drive reg");
        end
    endtask : t_drive

    task automatic t_periph;
        pin_in <= 16'ha5c3;
        periph_oe <= 16'h0080;
        periph_out <= 16'h0080;
        step(3);
        rd(`GPC_OFS_IN_LEVEL, 32'h0000_a5c3, OK, "input level");
        wr(PFS + 28, 32'h0301_c010, OK);
        step(1);
        chk(periph_in, 16'h0080, "periph in");
        chk({pin_oe[7], pin_out[7], pullup_on[7], irq_in_en[7], analog_en[7]}, 5'b11011, "periph pad");
        chk(periph_sel[39:35], 5'h03, "psel");
        rd(PFS + 28, 32'h0301_c012, OK, "pfs read");
    endtask : t_periph

    // ==========================================================
    // Run control
    task automatic conclude;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : conclude

    initial begin
        step(6);
        aresetn <= 1'b1;
        t_reset();
        t_guard();
        t_gpio();
        t_pullup();
        t_drive();
        t_periph();
        conclude();
    end

    initial begin
        #50us;
        n_errors++;
        $display("Error t=%0t watchdog", $time);
        conclude();
    end
endmodule : testbench
